/* hw/smia_device.sv */
// Switch memory device: indirect register access and transmit tristate
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module smia_device
	import smia_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	smia_if.dev bus,
	input wire logic [7:0] tx_slot,
	input wire logic [1:0] tx_subslot,
	input wire logic [7:0] rx_byte,
	output logic tx_bit_out,
	output logic tx_bit_oe,
	output logic tristate_ctl_line,
	output logic [3:0] timeslot_function_code,
	output logic [7:0] frame_side_port
);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FILL} smia_state_e;
	smia_state_e state_reg;
	logic [7:0] access_data_reg;
	logic [7:0] access_addr_reg;
	logic [7:0] access_ctrl_reg;
	logic access_pending_flag;
	logic [11:0] count_reg;
	logic [7:0] fill_idx_reg;
	logic [7:0] rdata_reg;
	logic [7:0] dm_data [SLOTS];
	logic [3:0] dm_tri [SLOTS / 2];
	logic [7:0] cm_data [SLOTS];
	logic [3:0] cm_code [SLOTS];
	logic [7:0] dm_rx [SLOTS / 2];
	logic [3:0] memory_op_code;
	logic read_sel;
	logic [7:0] up_addr;
	logic [6:0] tri_addr;
	logic ctrl_wr;
	assign memory_op_code = access_ctrl_reg[CTRL_OP_HI:CTRL_OP_LO];
	assign read_sel = access_ctrl_reg[CTRL_RW_BIT];
	assign up_addr = {1'b1, access_addr_reg[6:0]};
	assign tri_addr = access_addr_reg[6:0];
	assign ctrl_wr = bus.reg_wr && bus.reg_addr == REG_CTRL && !access_pending_flag;
	// Host registers; writes refused while pending
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			access_addr_reg <= RESET_BYTE;
			access_ctrl_reg <= RESET_BYTE;
		end else if (bus.reg_wr && !access_pending_flag) begin
			if (bus.reg_addr == REG_ADDR)
				access_addr_reg <= bus.reg_wdata;
			if (bus.reg_addr == REG_CTRL)
				access_ctrl_reg <= bus.reg_wdata;
		end
	end
	// Sequencer and pending flag
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			access_pending_flag <= 1'b0;
			count_reg <= 12'h000;
			fill_idx_reg <= 8'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (ctrl_wr) begin
						access_pending_flag <= 1'b1;
						state_reg <= (bus.reg_wdata[CTRL_OP_HI:CTRL_OP_LO] == OP_TS_ALL
							&& !bus.reg_wdata[CTRL_RW_BIT]) ? ST_FILL : ST_WAIT;
						count_reg <= 12'(SINGLE_CYC - 1);
						fill_idx_reg <= 8'h00;
					end
				end
				ST_WAIT: begin
					if (count_reg == 12'h000) begin
						access_pending_flag <= 1'b0;
						state_reg <= ST_IDLE;
					end else
						count_reg <= count_reg - 12'h001;
				end
				ST_FILL: begin
					fill_idx_reg <= fill_idx_reg + 8'h01;
					if (count_reg == 12'h000 && fill_idx_reg == 8'h7F) begin
						count_reg <= 12'(ALL_CYC - SLOTS / 2 - 1);
						state_reg <= ST_WAIT;
					end else if (count_reg != 12'h000)
						count_reg <= count_reg - 12'h001;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	// Memory operations, done at end of access time; the all-slot tristate fill runs at its start
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			access_data_reg <= RESET_BYTE;
		end else if (bus.reg_wr && !access_pending_flag && bus.reg_addr == REG_DATA) begin
			access_data_reg <= bus.reg_wdata;
		end else if (state_reg == ST_FILL) begin
			dm_tri[fill_idx_reg[6:0]] <= access_data_reg[3:0];
		end else if (state_reg == ST_WAIT && count_reg == 12'h000 && memory_op_code != OP_TS_ALL) begin
			if (read_sel) begin
				if (!memory_op_code[3])
					access_data_reg <= up_addr[7] == access_addr_reg[7]
						? dm_data[up_addr] : dm_rx[tri_addr];
				else if (memory_op_code == OP_TS_ONE)
					access_data_reg <= {4'h0, dm_tri[tri_addr]};
				else if (memory_op_code == OP_CM_DATA)
					access_data_reg <= cm_data[access_addr_reg];
				else if (memory_op_code[3:1] == 3'b111)
					access_data_reg <= {4'h0, cm_code[access_addr_reg]};
			end else begin
				case (memory_op_code)
					OP_DM_FULL: dm_data[up_addr] <= access_data_reg;
					OP_DM_LOW: dm_data[up_addr][3:0] <= access_data_reg[3:0];
					4'h3: dm_data[up_addr][7:4] <= access_data_reg[7:4];
					4'h7: dm_data[up_addr][7:6] <= access_data_reg[7:6];
					4'h6: dm_data[up_addr][5:4] <= access_data_reg[5:4];
					4'h5: dm_data[up_addr][3:2] <= access_data_reg[3:2];
					4'h4: dm_data[up_addr][1:0] <= access_data_reg[1:0];
					OP_TS_ONE: dm_tri[tri_addr] <= access_data_reg[3:0];
					OP_CM_DATA: cm_data[access_addr_reg] <= access_data_reg;
					4'hE, 4'hF: begin
						cm_data[access_addr_reg] <= access_data_reg;
						cm_code[access_addr_reg] <= access_ctrl_reg[3:0];
					end
					default: ;
				endcase
			end
		end
	end
	// Downstream receive capture
	always_ff @(posedge sys_clk) begin
		if (tx_subslot == 2'h3)
			dm_rx[tx_slot[6:0]] <= rx_byte;
	end
	// Register read port
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			rdata_reg <= RESET_BYTE;
		else if (bus.reg_rd)
			case (bus.reg_addr)
				REG_DATA: rdata_reg <= access_data_reg;
				REG_ADDR: rdata_reg <= access_addr_reg;
				REG_CTRL: rdata_reg <= access_ctrl_reg;
				default: rdata_reg <= {7'h00, access_pending_flag};
			endcase
		else
			rdata_reg <= RESET_BYTE;
	end
	assign bus.reg_rdata = rdata_reg;
	// Transmit line: subslot n sends bit 2n+1
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tx_bit_out <= 1'b0;
			tx_bit_oe <= 1'b0;
			tristate_ctl_line <= 1'b1;
			timeslot_function_code <= 4'h0;
			frame_side_port <= RESET_BYTE;
		end else begin
			tx_bit_oe <= dm_tri[tx_slot[6:0]][tx_subslot];
			tristate_ctl_line <= !dm_tri[tx_slot[6:0]][tx_subslot];
			tx_bit_out <= dm_tri[tx_slot[6:0]][tx_subslot]
				& dm_data[{1'b1, tx_slot[6:0]}][{tx_subslot, 1'b1}];
			timeslot_function_code <= cm_code[tx_slot];
			frame_side_port <= cm_data[tx_slot];
		end
	end
endmodule

/* hw/smia_host.sv */
// Host controller issuing indirect memory commands to the device
`timescale 1ns/100ps
module smia_host
	import smia_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	smia_if.host bus,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_ctrl,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic cmd_busy,
	output logic cmd_done,
	output logic [7:0] cmd_result
);
	typedef enum logic [2:0] {H_IDLE, H_DATA, H_ADDR, H_CTRL, H_POLL, H_CHECK, H_READ, H_TAKE} smia_hstate_e;
	smia_hstate_e state_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] addr_reg;
	logic [7:0] data_reg;
	logic [1:0] bus_addr_reg;
	logic [7:0] bus_wdata_reg;
	logic bus_wr_reg;
	logic bus_rd_reg;
	logic launched_reg;
	assign bus.reg_addr = bus_addr_reg;
	assign bus.reg_wdata = bus_wdata_reg;
	assign bus.reg_wr = bus_wr_reg;
	assign bus.reg_rd = bus_rd_reg;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= H_IDLE;
			ctrl_reg <= RESET_BYTE;
			addr_reg <= RESET_BYTE;
			data_reg <= RESET_BYTE;
			bus_addr_reg <= REG_DATA;
			bus_wdata_reg <= RESET_BYTE;
			bus_wr_reg <= 1'b0;
			bus_rd_reg <= 1'b0;
			launched_reg <= 1'b0;
			cmd_busy <= 1'b0;
			cmd_done <= 1'b0;
			cmd_result <= RESET_BYTE;
		end else begin
			bus_wr_reg <= 1'b0;
			bus_rd_reg <= 1'b0;
			cmd_done <= 1'b0;
			case (state_reg)
				H_IDLE: if (cmd_valid) begin
					ctrl_reg <= cmd_ctrl;
					addr_reg <= cmd_addr;
					data_reg <= cmd_data;
					cmd_busy <= 1'b1;
					state_reg <= H_POLL;
				end
				H_POLL: begin
					bus_addr_reg <= REG_STATUS;
					bus_rd_reg <= 1'b1;
					state_reg <= H_CHECK;
				end
				H_CHECK: state_reg <= H_TAKE;
				H_TAKE: begin
					if (bus.reg_rdata[0])
						state_reg <= H_POLL;
					else if (!cmd_busy)
						state_reg <= H_IDLE;
					else if (ctrl_reg[CTRL_RW_BIT]) begin
						state_reg <= launched_reg ? H_READ : H_ADDR;
					end else
						state_reg <= launched_reg ? H_IDLE : H_DATA;
					if (!bus.reg_rdata[0] && launched_reg) begin
						cmd_result <= RESET_BYTE;
						launched_reg <= 1'b0;
						if (!ctrl_reg[CTRL_RW_BIT]) begin
							cmd_busy <= 1'b0;
							cmd_done <= 1'b1;
						end
					end
				end
				H_DATA: begin
					bus_addr_reg <= REG_DATA;
					bus_wdata_reg <= data_reg;
					bus_wr_reg <= 1'b1;
					state_reg <= H_ADDR;
				end
				H_ADDR: begin
					bus_addr_reg <= REG_ADDR;
					bus_wdata_reg <= addr_reg;
					bus_wr_reg <= 1'b1;
					state_reg <= H_CTRL;
				end
				H_CTRL: begin
					bus_addr_reg <= REG_CTRL;
					bus_wdata_reg <= ctrl_reg;
					bus_wr_reg <= 1'b1;
					launched_reg <= 1'b1;
					state_reg <= H_POLL;
				end
				H_READ: begin
					if (!bus_rd_reg && bus_addr_reg != REG_DATA) begin
						bus_addr_reg <= REG_DATA;
						bus_rd_reg <= 1'b1;
					end else if (!bus_rd_reg) begin
						cmd_result <= bus.reg_rdata;
						cmd_busy <= 1'b0;
						cmd_done <= 1'b1;
						state_reg <= H_IDLE;
					end
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end
endmodule

/* hw/smia_if.sv */
// Register port between host controller and switch memory device
`timescale 1ns/100ps
interface smia_if;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	modport dev (input reg_addr, input reg_wdata, input reg_wr, input reg_rd, output reg_rdata);
	modport host (output reg_addr, output reg_wdata, output reg_wr, output reg_rd, input reg_rdata);
endinterface

/* hw/smia_pkg.sv */
// Shared constants for the switch memory indirect access block
package smia_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int SLOTS = 256;
	localparam logic [1:0] REG_DATA = 2'h0;
	localparam logic [1:0] REG_ADDR = 2'h1;
	localparam logic [1:0] REG_CTRL = 2'h2;
	localparam logic [1:0] REG_STATUS = 2'h3;
	localparam int CTRL_RW_BIT = 7;
	localparam int CTRL_OP_HI = 6;
	localparam int CTRL_OP_LO = 3;
	localparam int ADDR_UD_BIT = 7;
	localparam logic [3:0] OP_DM_FULL = 4'h1;
	localparam logic [3:0] OP_DM_LOW = 4'h2;
	localparam logic [3:0] OP_TS_ONE = 4'hC;
	localparam logic [3:0] OP_TS_ALL = 4'hD;
	localparam logic [3:0] OP_CM_DATA = 4'h9;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] RESET_TS = 4'h0;
	localparam int CLK_NS = 100;
	localparam int REF_NS = 250;
	localparam int SINGLE_REF_CYC = 10;
	localparam int ALL_REF_CYC = 1035;
	localparam int SINGLE_CYC = (SINGLE_REF_CYC * REF_NS + CLK_NS - 1) / CLK_NS;
	localparam int ALL_CYC = (ALL_REF_CYC * REF_NS + CLK_NS - 1) / CLK_NS;
	localparam int BIT_CYC = 1;
	localparam logic [7:0] CMD_TS_WRITE = 8'h60;
	localparam logic [7:0] CMD_TS_READ = 8'hE0;
	localparam logic [7:0] CMD_TS_ALL = 8'h68;
	localparam logic [7:0] CMD_CM_WRITE = 8'h48;
	localparam logic [7:0] CMD_CM_READ = 8'hC8;
	localparam logic [7:0] CMD_DM_READ = 8'h80;
endpackage

/* verification/smia_checker.sv */
// Timing and order checks on the host to device register port
`timescale 1ns/100ps
module smia_checker
	import smia_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	logic ctrl_wr;
	logic stat_q_reg;
	logic clear_reg;
	logic data_reg;
	logic fill_reg;
	logic [15:0] since_reg;
	assign ctrl_wr = reg_wr && reg_addr == REG_CTRL;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stat_q_reg <= 1'b0;
			clear_reg <= 1'b0;
			data_reg <= 1'b0;
			fill_reg <= 1'b0;
			since_reg <= 16'hFFFF;
		end else begin
			stat_q_reg <= reg_rd && reg_addr == REG_STATUS;
			clear_reg <= ctrl_wr ? 1'b0 : (clear_reg || (stat_q_reg && !reg_rdata[0]));
			data_reg <= ctrl_wr ? 1'b0 : (data_reg || (reg_wr && reg_addr == REG_DATA));
			fill_reg <= ctrl_wr ? reg_wdata == CMD_TS_ALL : fill_reg;
			since_reg <= ctrl_wr ? 16'h0000 : (since_reg == 16'hFFFF ? since_reg : since_reg + 16'h0001);
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_strobe_excl; !(reg_wr && reg_rd); endproperty
	a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes high");
	property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	property p_no_wr_pend; ctrl_wr |=> (!reg_wr || reg_addr == REG_STATUS) [*8]; endproperty
	a_no_wr_pend: assert property (p_no_wr_pend) else $error("write while pending");
	property p_pend_set; ctrl_wr ##[1:5] (reg_rd && reg_addr == REG_STATUS) |=> reg_rdata[0]; endproperty
	a_pend_set: assert property (p_pend_set) else $error("pending not set");
	property p_ctrl_ready; ctrl_wr |-> clear_reg; endproperty
	a_ctrl_ready: assert property (p_ctrl_ready) else $error("launch without idle status");
	property p_rd_clear; reg_rd && reg_addr == REG_DATA |-> clear_reg; endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("data read before clear");
	property p_data_first; ctrl_wr && !reg_wdata[CTRL_RW_BIT] |-> data_reg; endproperty
	a_data_first: assert property (p_data_first) else $error("write launch without data");
	property p_min_time; stat_q_reg && !reg_rdata[0] && since_reg != 16'hFFFF |->
		since_reg >= (fill_reg ? ALL_CYC : SINGLE_CYC) - 1; endproperty
	a_min_time: assert property (p_min_time) else $error("operation ended early");
	property p_max_time; stat_q_reg && reg_rdata[0] |-> since_reg <= ALL_CYC + 2; endproperty
	a_max_time: assert property (p_max_time) else $error("operation too long");
endmodule

/* verification/smia_tb_top.sv */
// Testbench for host controller and device joined by the register port
`timescale 1ns/100ps
module smia_tb_top
	import smia_pkg::*;
;
	logic sys_clk, sys_rst, cmd_valid, cmd_busy, cmd_done, tx_bit_out, tx_bit_oe, tsc;
	logic [7:0] cmd_ctrl, cmd_addr, cmd_data, cmd_result, tx_slot, rx_byte, fport, rv;
	logic [1:0] tx_subslot;
	logic [3:0] fcode;
	int n_mismatch, compares, cyc, n;
	smia_if u_link();
	smia_if u_link2();
	smia_device u_smia_device(.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(u_link.dev), .tx_slot(tx_slot),
		.tx_subslot(tx_subslot), .rx_byte(rx_byte), .tx_bit_out(tx_bit_out), .tx_bit_oe(tx_bit_oe),
		.tristate_ctl_line(tsc), .timeslot_function_code(fcode), .frame_side_port(fport));
	smia_device u_smia_device_2(.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(u_link2.dev), .tx_slot(tx_slot),
		.tx_subslot(tx_subslot), .rx_byte(rx_byte), .tx_bit_out(), .tx_bit_oe(),
		.tristate_ctl_line(), .timeslot_function_code(), .frame_side_port());
	smia_host u_smia_host(.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(u_link.host), .cmd_valid(cmd_valid),
		.cmd_ctrl(cmd_ctrl), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_busy(cmd_busy),
		.cmd_done(cmd_done), .cmd_result(cmd_result));
	smia_checker u_smia_checker(.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(u_link.reg_addr),
		.reg_wdata(u_link.reg_wdata), .reg_wr(u_link.reg_wr), .reg_rd(u_link.reg_rd), .reg_rdata(u_link.reg_rdata));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task report_and_stop();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task cmd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cmd_ctrl <= c;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_valid <= 1'b1;
		do @(negedge sys_clk); while (cmd_busy !== 1'b1);
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		while (cmd_done !== 1'b1) @(negedge sys_clk);
	endtask
	task wr2(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		u_link2.reg_addr <= a;
		u_link2.reg_wdata <= d;
		u_link2.reg_wr <= 1'b1;
		@(posedge sys_clk);
		u_link2.reg_wr <= 1'b0;
	endtask
	task rd2(input logic [1:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		u_link2.reg_addr <= a;
		u_link2.reg_rd <= 1'b1;
		@(posedge sys_clk);
		u_link2.reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = u_link2.reg_rdata;
	endtask
	task poll2();
		do rd2(REG_STATUS, rv); while (rv[0] !== 1'b0);
	endtask
	initial begin
		{cmd_valid, cmd_ctrl, cmd_addr, cmd_data, tx_subslot} = '0;
		tx_slot = 8'h00;
		rx_byte = 8'h5C;
		{u_link2.reg_addr, u_link2.reg_wdata, u_link2.reg_wr, u_link2.reg_rd} = '0;
		sys_rst = 1'b1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		cmd(8'h08, 8'hC0, 8'hA5);
		cmd(CMD_DM_READ, 8'hC0, 8'h00);
		chk("dm byte", 8'hA5, cmd_result);
		cmd(8'h08, 8'h3F, 8'hFF);
		cmd(8'h10, 8'hBF, 8'h06);
		cmd(CMD_DM_READ, 8'hBF, 8'h00);
		chk("dm nibble", 8'hF6, cmd_result);
		cmd(CMD_TS_ALL, 8'h00, 8'hFA);
		cmd(CMD_TS_READ, 8'h85, 8'h00);
		chk("ts fill", 8'h0A, {4'h0, cmd_result[3:0]});
		cmd(CMD_TS_WRITE, 8'h40, 8'hF9);
		cmd(CMD_TS_READ, 8'hC0, 8'h00);
		chk("ts one", 8'h09, {4'h0, cmd_result[3:0]});
		tx_slot <= 8'hC0;
		for (n = 0; n < 4; n++) begin
			tx_subslot <= n[1:0];
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			chk("oe", {7'h0, 1'(4'h9 >> n)}, {7'h0, tx_bit_oe});
			chk("tsc", {7'h0, !(4'h9 >> n & 1'b1)}, {7'h0, tsc});
			chk("bit", {7'h0, (4'h9 >> n & 1'b1) && 8'hA5 >> (2 * n + 1) & 1'b1}, {7'h0, tx_bit_out});
		end
		cmd(CMD_CM_WRITE, 8'h7B, 8'h3C);
		cmd(CMD_CM_READ, 8'h7B, 8'h00);
		chk("cm data", 8'h3C, cmd_result);
		cmd(8'h71, 8'h7B, 8'h5A);
		cmd(CMD_CM_READ, 8'h7B, 8'h00);
		chk("cm both", 8'h5A, cmd_result);
		cmd(8'hF0, 8'h7B, 8'h00);
		chk("cm code", 8'h01, {4'h0, cmd_result[3:0]});
		cmd(CMD_CM_WRITE, 8'h7B, 8'h11);
		tx_slot <= 8'h7B;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("function", 8'h01, {4'h0, fcode});
		chk("cm port", 8'h11, fport);
		wr2(REG_DATA, 8'h33);
		wr2(REG_ADDR, 8'hC1);
		wr2(REG_CTRL, 8'h08);
		rd2(REG_STATUS, rv);
		chk("pending", 8'h01, {7'h0, rv[0]});
		wr2(REG_DATA, 8'h77);
		poll2();
		rd2(REG_DATA, rv);
		chk("refused", 8'h33, rv);
		wr2(REG_CTRL, CMD_DM_READ);
		poll2();
		rd2(REG_DATA, rv);
		chk("dm reread", 8'h33, rv);
		report_and_stop();
	end
endmodule
